// ---- design/ptp_mode_pkg.sv ----
// Purpose: shared constants and types for the mode and start-up controller
// Assumes: 100 ns core clock, one host call per request strobe
// Notes: register map, parameter layout, modes and answer codes live here

package ptp_mode_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int INIT_TIME_NS = 2000;
  localparam int REPARAM_TIME_NS = 1000;
  // least times round up to whole cycles
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REPARAM_CYCLES = (REPARAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 8;

  // ****************************************************************
  // host call counts per request kind
  // ****************************************************************
  localparam logic [2:0] SYNC_CALLS = 3'd2;
  localparam logic [2:0] XFER_CALLS = 3'd3;
  localparam logic [2:0] RESET_CALLS = 3'd4;
  localparam logic [2:0] LSTAT_CALLS = 3'd1;
  localparam logic [2:0] LSET_CALLS = 3'd2;

  // ****************************************************************
  // register port
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_PARAM = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_CAUSE = 4'h2;
  localparam int STAT_MODE = 0;
  localparam int STAT_FAULT = 2;
  localparam int STAT_TX_BUSY = 3;
  localparam int STAT_SYNC = 4;
  localparam int STAT_ABORT_TX = 5;
  localparam int STAT_ABORT_RX = 6;
  localparam int STAT_RX_COUNT = 8;
  localparam int CAUSE_BREAK = 0;
  localparam int CAUSE_PARAM = 1;
  localparam logic [7:0] RX_FRAMES_MIN = 8'h01;
  localparam logic [7:0] RX_FRAMES_MAX = 8'hFA;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_INIT = 2'b00,
    MODE_STOP = 2'b01,
    MODE_REPARAM = 2'b10,
    MODE_RUN = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    DRV_BLOCK_CHECK = 2'b00,
    DRV_ASCII = 2'b01,
    DRV_PRINTER = 2'b10
  } drv_e;

  typedef enum logic [2:0] {
    KIND_SEND = 3'b000,
    KIND_PRINT = 3'b001,
    KIND_RECV = 3'b010,
    KIND_RESET = 3'b011,
    KIND_LSTAT = 3'b100,
    KIND_LSET = 3'b101
  } kind_e;

  typedef enum logic [1:0] {
    ANS_OK = 2'b00,
    ANS_NAK = 2'b01,
    ANS_ABORT = 2'b10
  } ans_e;

  typedef struct packed {
    logic [3:0] baud;
    logic [7:0] rx_frames;
    logic clear_rx;
    logic flow_ctrl;
    logic [1:0] driver;
  } param_s;

  typedef struct packed {
    logic call;
    kind_e kind;
    logic data_last;
  } host_req_s;

  typedef struct packed {
    logic done;
    ans_e code;
  } host_ans_s;

  localparam param_s PARAM_DEFAULT = '{
    baud: 4'h6, rx_frames: 8'h0A, clear_rx: 1'b0, flow_ctrl: 1'b0, driver: 2'b00};
  localparam host_ans_s ANS_IDLE = '{done: 1'b0, code: ANS_OK};

  // parameter set is usable only with a known driver and a legal buffer size
  function automatic logic param_ok(input param_s p);
    param_ok = (p.driver != 2'b11) && (p.rx_frames >= RX_FRAMES_MIN)
      && (p.rx_frames <= RX_FRAMES_MAX);
  endfunction : param_ok

endpackage : ptp_mode_pkg

// ---- design/ptp_comm_mode_control.sv ----
// Purpose: operating mode, start-up and host request control of the serial module
// Assumes: all inputs synchronous to core_clk_i; one host call is one req.call pulse
// Notes: serial driver itself sits outside; this block gates and sequences it

`timescale 1ns/1ps

// Summary of operation
// - stop mode: no driver, every request refused
// - stop holds until break and bad parameters clear
// - reparameterization reinitializes driver, fault indicator on
// - reparameterization refuses traffic, flushes frames, restarts host
// - reparameterization ends in run mode
// - run mode serves sends and holds received frames
// - power-up loads factory default parameters
// - after init start block-check driver, report ready
// - received parameter set triggers reparameterization
// - reparameterize only when parameter set differs
// - host stop aborts transfers, reconnects host
// - ascii/printer without flow control keep serial running
// - synchronization exchange before any new request
// - early sends kept; receive waits for exchange
// - sends and prints accepted only in host run
// - send interrupted by host stop ends aborted
// - serial send starts only after complete data
// - clear option empties buffer on host start
// - otherwise keep configured 1 to 250 frames
// - interrupted receive reports abort, frame resent
// - request completion call counts per kind
module ptp_comm_mode_control (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [ptp_mode_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [ptp_mode_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [ptp_mode_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic host_run_i,
  input wire ptp_mode_pkg::host_req_s host_req_i,
  output ptp_mode_pkg::host_ans_s host_ans_o,
  input wire logic line_break_i,
  input wire logic rx_frame_i,
  input wire logic tx_done_i,
  output logic tx_start_o,
  output logic serial_enable_o,
  output logic group_fault_indicator_o,
  output logic ready_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  ptp_mode_pkg::mode_e mode;
  ptp_mode_pkg::mode_e next_mode;
  ptp_mode_pkg::param_s active_param;
  ptp_mode_pkg::param_s new_param;
  ptp_mode_pkg::kind_e cur_kind;
  logic param_pend;
  logic param_bad;
  logic [ptp_mode_pkg::TIMER_W-1:0] timer;
  logic reparam_entry;
  logic host_run_q;
  logic host_stop_edge;
  logic host_start_edge;
  logic [2:0] call_cnt;
  logic [2:0] sync_cnt;
  logic [2:0] need_calls;
  logic data_seen;
  logic abort_tx;
  logic abort_rx;
  logic tx_busy;
  logic [7:0] rx_count;
  logic serial_ok;
  logic rx_accept;
  logic rx_pop;
  logic send_fire;
  ptp_mode_pkg::param_s wr_param;

  assign wr_param = ptp_mode_pkg::param_s'(reg_wdata_i);
  assign host_stop_edge = host_run_q && !host_run_i;
  assign host_start_edge = !host_run_q && host_run_i;

  // mode sequencing; in run mode, break and bad parameters force stop
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      ptp_mode_pkg::MODE_INIT:
      begin
        if (timer == '0)
        begin
          next_mode = ptp_mode_pkg::MODE_RUN;
        end
      end
      ptp_mode_pkg::MODE_STOP:
      begin
        if (!line_break_i && !param_bad)
        begin
          next_mode = ptp_mode_pkg::MODE_REPARAM;
        end
      end
      ptp_mode_pkg::MODE_REPARAM:
      begin
        if (timer == '0)
        begin
          next_mode = ptp_mode_pkg::MODE_RUN;
        end
      end
      ptp_mode_pkg::MODE_RUN:
      begin
        if (line_break_i || param_bad)
        begin
          next_mode = ptp_mode_pkg::MODE_STOP;
        end
        else if (param_pend)
        begin
          next_mode = ptp_mode_pkg::MODE_REPARAM;
        end
      end
    endcase
  end

  assign reparam_entry = (next_mode == ptp_mode_pkg::MODE_REPARAM)
    && (mode != ptp_mode_pkg::MODE_REPARAM);

  // ****************************************************************
  // mode register and phase timer
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mode <= ptp_mode_pkg::MODE_INIT;
      timer <= ptp_mode_pkg::TIMER_W'(ptp_mode_pkg::INIT_CYCLES - 1);
    end
    else
    begin
      mode <= next_mode;
      if (reparam_entry)
      begin
        timer <= ptp_mode_pkg::TIMER_W'(ptp_mode_pkg::REPARAM_CYCLES - 1);
      end
      else if (timer != '0)
      begin
        timer <= timer - 1'b1;
      end
    end
  end

  // parameter intake; an identical set changes nothing
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      active_param <= ptp_mode_pkg::PARAM_DEFAULT;
      new_param <= ptp_mode_pkg::PARAM_DEFAULT;
      param_pend <= 1'b0;
      param_bad <= 1'b0;
    end
    else if (reg_write_i && reg_addr_i == ptp_mode_pkg::REG_PARAM)
    begin
      new_param <= wr_param;
      param_bad <= !ptp_mode_pkg::param_ok(wr_param);
      param_pend <= ptp_mode_pkg::param_ok(wr_param) && (wr_param != active_param);
    end
    else if (reparam_entry)
    begin
      active_param <= new_param;
      param_pend <= 1'b0;
    end
  end

  // ****************************************************************
  // serial side
  // ****************************************************************
  // stopped host halts the link except ascii/printer without flow control
  assign serial_ok = (mode == ptp_mode_pkg::MODE_RUN) && (host_run_i
    || ((active_param.driver == ptp_mode_pkg::DRV_ASCII
    || active_param.driver == ptp_mode_pkg::DRV_PRINTER)
    && !active_param.flow_ctrl));
  // buffer full refuses further frames
  assign rx_accept = rx_frame_i && serial_ok && (rx_count < active_param.rx_frames);

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      host_run_q <= 1'b0;
    end
    else
    begin
      host_run_q <= host_run_i;
    end
  end

  // receive buffer occupancy; flush wins over arrival
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_count <= 8'h00;
    end
    else if (reparam_entry)
    begin
      rx_count <= 8'h00;
    end
    else if (host_start_edge && active_param.clear_rx)
    begin
      rx_count <= 8'h00;
    end
    else if (rx_accept && !rx_pop)
    begin
      rx_count <= rx_count + 1'b1;
    end
    else if (rx_pop && !rx_accept)
    begin
      rx_count <= rx_count - 1'b1;
    end
  end

  // running send is allowed to finish even after the host stops
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_busy <= 1'b0;
    end
    else if (reparam_entry)
    begin
      tx_busy <= 1'b0;
    end
    else if (send_fire)
    begin
      tx_busy <= 1'b1;
    end
    else if (tx_done_i)
    begin
      tx_busy <= 1'b0;
    end
  end

  // ****************************************************************
  // host request engine
  // ****************************************************************
  always_comb
  begin
    unique case (cur_kind)
      ptp_mode_pkg::KIND_RESET: need_calls = ptp_mode_pkg::RESET_CALLS;
      ptp_mode_pkg::KIND_LSTAT: need_calls = ptp_mode_pkg::LSTAT_CALLS;
      ptp_mode_pkg::KIND_LSET: need_calls = ptp_mode_pkg::LSET_CALLS;
      default: need_calls = ptp_mode_pkg::XFER_CALLS;
    endcase
  end

  logic run_call;
  logic hold_call;
  logic synced;
  logic last_call;
  logic is_send;
  assign synced = (sync_cnt == ptp_mode_pkg::SYNC_CALLS);
  assign run_call = host_req_i.call && host_run_i && (mode == ptp_mode_pkg::MODE_RUN);
  assign last_call = run_call && synced && (call_cnt != 3'd0)
    && (call_cnt + 3'd1 >= need_calls);
  assign is_send = (cur_kind == ptp_mode_pkg::KIND_SEND)
    || (cur_kind == ptp_mode_pkg::KIND_PRINT);
  // a send without its last data or with the link busy keeps taking calls
  assign hold_call = is_send && !abort_tx && (tx_busy
    || !(data_seen || host_req_i.data_last));
  // frame leaves only once all host data arrived and the link is free
  assign send_fire = last_call && is_send && !abort_tx && (data_seen
    || host_req_i.data_last) && !tx_busy;
  assign rx_pop = last_call && (cur_kind == ptp_mode_pkg::KIND_RECV) && !abort_rx
    && (rx_count != 8'h00);

  // call counting, synchronization and abort bookkeeping
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      call_cnt <= 3'd0;
      sync_cnt <= 3'd0;
      cur_kind <= ptp_mode_pkg::KIND_SEND;
      data_seen <= 1'b0;
      abort_tx <= 1'b0;
      abort_rx <= 1'b0;
    end
    else if (reparam_entry)
    begin
      call_cnt <= 3'd0;
      sync_cnt <= 3'd0;
      data_seen <= 1'b0;
      abort_tx <= 1'b0;
      abort_rx <= 1'b0;
    end
    else if (host_stop_edge)
    begin
      call_cnt <= 3'd0;
      sync_cnt <= 3'd0;
      data_seen <= 1'b0;
      if (call_cnt != 3'd0 && is_send)
      begin
        abort_tx <= 1'b1;
      end
      if (call_cnt != 3'd0 && cur_kind == ptp_mode_pkg::KIND_RECV)
      begin
        abort_rx <= 1'b1;
      end
    end
    else if (run_call && !synced)
    begin
      sync_cnt <= sync_cnt + 3'd1;
    end
    else if (run_call && call_cnt == 3'd0)
    begin
      // a receive call with nothing stored is only a poll
      if (host_req_i.kind != ptp_mode_pkg::KIND_RECV || rx_count != 8'h00
        || abort_rx)
      begin
        cur_kind <= host_req_i.kind;
        data_seen <= host_req_i.data_last;
        call_cnt <= 3'd1;
      end
      // status read finishes on its single call, nothing left open
      if (host_req_i.kind == ptp_mode_pkg::KIND_LSTAT)
      begin
        call_cnt <= 3'd0;
      end
    end
    else if (last_call && !hold_call)
    begin
      call_cnt <= 3'd0;
      data_seen <= 1'b0;
      if (is_send)
      begin
        abort_tx <= 1'b0;
      end
      if (cur_kind == ptp_mode_pkg::KIND_RECV)
      begin
        abort_rx <= 1'b0;
      end
    end
    else if (run_call && call_cnt != 3'd0)
    begin
      call_cnt <= call_cnt + 3'd1;
      data_seen <= data_seen || host_req_i.data_last;
    end
  end

  // answers: refusal outside run, abort after an interrupted transfer
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      host_ans_o <= ptp_mode_pkg::ANS_IDLE;
    end
    else
    begin
      host_ans_o <= ptp_mode_pkg::ANS_IDLE;
      if (host_req_i.call && host_run_i && mode != ptp_mode_pkg::MODE_RUN)
      begin
        host_ans_o <= '{done: 1'b1, code: ptp_mode_pkg::ANS_NAK};
      end
      else if (run_call && synced && call_cnt == 3'd0
        && host_req_i.kind == ptp_mode_pkg::KIND_LSTAT)
      begin
        host_ans_o <= '{done: 1'b1, code: ptp_mode_pkg::ANS_OK};
      end
      else if (last_call && is_send && abort_tx)
      begin
        host_ans_o <= '{done: 1'b1, code: ptp_mode_pkg::ANS_ABORT};
      end
      else if (last_call && cur_kind == ptp_mode_pkg::KIND_RECV && abort_rx)
      begin
        host_ans_o <= '{done: 1'b1, code: ptp_mode_pkg::ANS_ABORT};
      end
      else if (last_call && !hold_call)
      begin
        host_ans_o <= '{done: 1'b1, code: ptp_mode_pkg::ANS_OK};
      end
    end
  end

  // ****************************************************************
  // outputs and register reads
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_start_o <= 1'b0;
      serial_enable_o <= 1'b0;
      group_fault_indicator_o <= 1'b1;
      ready_o <= 1'b0;
    end
    else
    begin
      tx_start_o <= send_fire;
      serial_enable_o <= serial_ok;
      group_fault_indicator_o <= (next_mode == ptp_mode_pkg::MODE_REPARAM)
        || (next_mode == ptp_mode_pkg::MODE_INIT);
      ready_o <= (next_mode == ptp_mode_pkg::MODE_RUN);
    end
  end

  // unmapped addresses read as zero; data valid one cycle after the strobe
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= '0;
    end
    else
    begin
      reg_rdata_o <= '0;
      if (reg_read_i)
      begin
        unique case (reg_addr_i)
          ptp_mode_pkg::REG_PARAM: reg_rdata_o <= active_param;
          ptp_mode_pkg::REG_STATUS:
          begin
            reg_rdata_o[ptp_mode_pkg::STAT_MODE +: 2] <= mode;
            reg_rdata_o[ptp_mode_pkg::STAT_FAULT] <= group_fault_indicator_o;
            reg_rdata_o[ptp_mode_pkg::STAT_TX_BUSY] <= tx_busy;
            reg_rdata_o[ptp_mode_pkg::STAT_SYNC] <= !synced;
            reg_rdata_o[ptp_mode_pkg::STAT_ABORT_TX] <= abort_tx;
            reg_rdata_o[ptp_mode_pkg::STAT_ABORT_RX] <= abort_rx;
            reg_rdata_o[ptp_mode_pkg::STAT_RX_COUNT +: 8] <= rx_count;
          end
          ptp_mode_pkg::REG_CAUSE:
          begin
            reg_rdata_o[ptp_mode_pkg::CAUSE_BREAK] <= line_break_i;
            reg_rdata_o[ptp_mode_pkg::CAUSE_PARAM] <= param_bad;
          end
          default: reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_stop_nak;
    @(posedge core_clk_i) disable iff (reset_i)
    (mode == ptp_mode_pkg::MODE_STOP && host_req_i.call && host_run_i)
      |=> (host_ans_o.done && host_ans_o.code == ptp_mode_pkg::ANS_NAK);
  endproperty
  a_stop_nak: assert property (p_stop_nak) else $error("stop call not refused");

  property p_stop_hold;
    @(posedge core_clk_i) disable iff (reset_i)
    (mode == ptp_mode_pkg::MODE_STOP && line_break_i) |=> (mode == ptp_mode_pkg::MODE_STOP);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left with break");

  property p_reparam_fault;
    @(posedge core_clk_i) disable iff (reset_i)
    (mode == ptp_mode_pkg::MODE_REPARAM) |-> group_fault_indicator_o;
  endproperty
  a_reparam_fault: assert property (p_reparam_fault) else $error("fault off in reparam");

  property p_reparam_flush;
    @(posedge core_clk_i) disable iff (reset_i)
    reparam_entry |=> (rx_count == 8'h00 && call_cnt == 3'd0 && !tx_busy);
  endproperty
  a_reparam_flush: assert property (p_reparam_flush) else $error("reparam did not flush");

  property p_reparam_end;
    @(posedge core_clk_i) disable iff (reset_i)
    reparam_entry |=> (mode == ptp_mode_pkg::MODE_REPARAM) [*8] ##1
      (mode == ptp_mode_pkg::MODE_REPARAM) [*2] ##1 (mode == ptp_mode_pkg::MODE_RUN);
  endproperty
  a_reparam_end: assert property (p_reparam_end) else $error("reparam length wrong");

  property p_init_default;
    @(posedge core_clk_i) disable iff (reset_i)
    (mode == ptp_mode_pkg::MODE_INIT) |-> (active_param == ptp_mode_pkg::PARAM_DEFAULT);
  endproperty
  a_init_default: assert property (p_init_default) else $error("init params not default");

  property p_tx_after_data;
    @(posedge core_clk_i) disable iff (reset_i)
    tx_start_o |-> $past(data_seen || host_req_i.data_last) && $past(host_run_i);
  endproperty
  a_tx_after_data: assert property (p_tx_after_data) else $error("send before data");

  property p_clear_on_start;
    @(posedge core_clk_i) disable iff (reset_i)
    (host_start_edge && active_param.clear_rx && !reparam_entry) |=> (rx_count == 8'h00);
  endproperty
  a_clear_on_start: assert property (p_clear_on_start) else $error("buffer kept");

  property p_rx_limit;
    @(posedge core_clk_i) disable iff (reset_i)
    (rx_count <= active_param.rx_frames) || $past(reparam_entry);
  endproperty
  a_rx_limit: assert property (p_rx_limit) else $error("buffer over limit");

  property p_sync_first;
    @(posedge core_clk_i) disable iff (reset_i)
    (!synced) |-> !host_ans_o.done || host_ans_o.code == ptp_mode_pkg::ANS_NAK
      || $past(last_call);
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("request before sync");

endmodule : ptp_comm_mode_control

// ---- dv/host_partner.sv ----
// Purpose: host controller model issuing block calls to the module
// Assumes: calls change right after a rising edge, one call per cycle
// Notes: answer is sampled in the cycle after the last call

`timescale 1ns/1ps

module host_partner (
  input wire logic clk_i,
  input wire ptp_mode_pkg::host_ans_s ans_i,
  output ptp_mode_pkg::host_req_s req_o,
  output logic run_o
);
  // ****
  // host side
  // ****
  // host starts stopped, no call pending
  initial
  begin
    req_o = '0;
    run_o = 1'b0;
  end

  // n block calls in a row; the answer only stands one cycle
  task automatic call(input ptp_mode_pkg::kind_e k, input logic l, input int n,
    output ptp_mode_pkg::host_ans_s a);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      req_o <= '{1'b1, k, l};
    end
    @(posedge clk_i);
    req_o <= '{1'b0, k, 1'b0};
    #1 a = ans_i;
  endtask : call

  // host mode level, changed at an edge
  task automatic run(input logic r);
    @(posedge clk_i);
    run_o <= r;
  endtask : run

endmodule : host_partner

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the mode and start-up controller
// Assumes: host partner drives calls, bench drives registers and serial side
// Notes: integer model tracks buffered frames and call counts

`timescale 1ns/1ps

module testbench;
  logic core_clk_i, reset_i, reg_write_i, reg_read_i, line_break_i, rx_frame_i, tx_done_i;
  logic tx_start_o, serial_enable_o, group_fault_indicator_o, ready_o, host_run_i;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, v, p;
  ptp_mode_pkg::host_req_s host_req_i;
  ptp_mode_pkg::host_ans_s host_ans_o, ans;
  int miscompares, compares, cyc, rxm;

  ptp_comm_mode_control i_ptp_comm_mode_control (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .host_run_i(host_run_i),
    .host_req_i(host_req_i), .host_ans_o(host_ans_o), .line_break_i(line_break_i),
    .rx_frame_i(rx_frame_i), .tx_done_i(tx_done_i), .tx_start_o(tx_start_o),
    .serial_enable_o(serial_enable_o), .group_fault_indicator_o(group_fault_indicator_o),
    .ready_o(ready_o));
  host_partner i_host_partner (.clk_i(core_clk_i), .ans_i(host_ans_o), .req_o(host_req_i),
    .run_o(host_run_i));

  // ****
  // clock and hang guard
  // ****
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // whole run is under two hundred cycles
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  // ****
  // tasks and model
  // ****
  task automatic close_out();
    $display("miscompares %0d compares %0d", miscompares, compares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // model of calls needed per request kind
  function automatic int ncalls(input int k);
    return (k == 4) ? 1 : (k == 5) ? 2 : (k == 3) ? 4 : 3;
  endfunction : ncalls

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd

  // e is {done, code}; code ignored without done
  task automatic req(input int k, input int n, input logic l, input logic [2:0] e);
    i_host_partner.call(ptp_mode_pkg::kind_e'(k), l, n, ans);
    chk("answer", {13'h0, ans.done, ans.code & {2{ans.done}}}, {13'h0, e});
  endtask : req

  task automatic sync(input logic rise);
    if (rise)
    begin
      i_host_partner.run(1'b0);
      i_host_partner.run(1'b1);
    end
    repeat (2) req(0, 1, 1'b0, 3'b000);
  endtask : sync

  task automatic frame();
    @(posedge core_clk_i);
    rx_frame_i <= 1'b1;
    @(posedge core_clk_i);
    rx_frame_i <= 1'b0;
  endtask : frame

  task automatic txd();
    @(posedge core_clk_i);
    tx_done_i <= 1'b1;
    @(posedge core_clk_i);
    tx_done_i <= 1'b0;
  endtask : txd

  // ****
  // main sequence
  // ****
  initial
  begin
    {reset_i, reg_write_i, reg_read_i, line_break_i, rx_frame_i, tx_done_i} = 6'h20;
    {reg_addr_i, reg_wdata_i, cyc, rxm, miscompares, compares} = '0;
    void'($urandom(32'hAAD9));
    repeat (5) @(posedge core_clk_i);
    chk("fault", 16'(group_fault_indicator_o), 16'h1);
    reset_i <= 1'b0;
    repeat (25) @(posedge core_clk_i);
    #1 chk("ready", 16'({ready_o, group_fault_indicator_o}), 16'h2);
    rd(ptp_mode_pkg::REG_PARAM);
    chk("param", v, ptp_mode_pkg::PARAM_DEFAULT);
    sync(1'b1);
    for (int i = 1; i < 6; i++)
      if (i != 2) req(i, ncalls(i), 1'b1, 3'b100);
    txd();
    frame();
    rxm++;
    rd(ptp_mode_pkg::REG_STATUS);
    chk("rx_count", 16'(v[15:8]), 16'(rxm));
    req(2, 3, 1'b0, 3'b100);
    rxm--;
    // no data_last: send must hold
    req(0, 3, 1'b0, 3'b000);
    req(0, 1, 1'b1, 3'b100);
    chk("tx_start", 16'(tx_start_o), 16'h1);
    txd();
    // host stop in mid receive, frame kept
    frame();
    req(2, 1, 1'b0, 3'b000);
    sync(1'b1);
    req(2, 3, 1'b0, 3'b110);
    req(2, 3, 1'b0, 3'b100);
    req(0, 1, 1'b1, 3'b000);
    sync(1'b1);
    req(0, 3, 1'b1, 3'b110);
    // new set: ascii, 2 frames, clear at start
    p = {4'($urandom), 8'h02, 1'b1, 1'b0, 2'b01};
    wr(ptp_mode_pkg::REG_PARAM, p);
    repeat (2) @(posedge core_clk_i);
    #1 chk("fault", 16'({ready_o, group_fault_indicator_o}), 16'h1);
    req(4, 1, 1'b1, 3'b101);
    repeat (12) @(posedge core_clk_i);
    #1 chk("ready", 16'({ready_o, group_fault_indicator_o}), 16'h2);
    rd(ptp_mode_pkg::REG_PARAM);
    chk("param", v, p);
    sync(1'b0);
    repeat (3)
    begin
      frame();
      if (rxm < 2) rxm++;
    end
    rd(ptp_mode_pkg::REG_STATUS);
    chk("rx_count", 16'(v[15:8]), 16'(rxm));
    i_host_partner.run(1'b0);
    repeat (2) @(posedge core_clk_i);
    #1 chk("serial", 16'(serial_enable_o), 16'h1);
    i_host_partner.run(1'b1);
    rd(ptp_mode_pkg::REG_STATUS);
    chk("rx_count", 16'(v[15:8]), 16'h0);
    wr(ptp_mode_pkg::REG_PARAM, p);
    repeat (3) @(posedge core_clk_i);
    #1 chk("fault", 16'(group_fault_indicator_o), 16'h0);
    @(posedge core_clk_i);
    line_break_i <= 1'b1;
    rd(ptp_mode_pkg::REG_STATUS);
    chk("mode", 16'({v[1:0], serial_enable_o}), 16'h2);
    req(0, 1, 1'b1, 3'b101);
    @(posedge core_clk_i);
    line_break_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1 chk("ready", 16'(ready_o), 16'h0);
    repeat (8) @(posedge core_clk_i);
    #1 chk("ready", 16'(ready_o), 16'h1);
    close_out();
  end

endmodule : testbench
